// ===== logic/msg_regs_pkg.sv
// Shared constants for the controller register exchange block
package msg_regs_pkg;
  // Word indices inside the sixteen-word blocks (word n is index n-1)
  localparam logic [3:0] OW_FLAGS = 4'h0;
  localparam logic [3:0] OW_MSG = 4'h1;
  localparam logic [3:0] OW_PRIO = 4'h2;
  localparam logic [3:0] OW_DS0 = 4'h3;
  localparam logic [3:0] OW_CLR = 4'h7;
  localparam logic [3:0] OW_LAMP = 4'h8;
  localparam logic [3:0] OW_FKEN = 4'hB;
  localparam logic [3:0] OW_SLAVE = 4'hE;
  localparam logic [3:0] IW_FLAGS = 4'h0;
  localparam logic [3:0] IW_DS0 = 4'h1;
  localparam logic [3:0] IW_FKEY = 4'h5;
  localparam logic [3:0] IW_CLK0 = 4'h8;
  // Command flag bits, low means valid or enabled
  localparam int FB_MSG = 0;
  localparam int FB_DS = 1;
  localparam int FB_CLR = 2;
  localparam int FB_LAMP = 3;
  localparam int FB_LOCK0 = 4;
  localparam int FB_QUEUE = 8;
  localparam int FB_SLAVE = 13;
  // Status flag bits
  localparam int SB_ENTER0 = 4;
  localparam int SB_CHG0 = 8;
  localparam int SB_FULL = 12;
  localparam int SB_SLAVE = 13;
  // Slave selector fields
  localparam int UNIT_LSB = 0;
  localparam int UNIT_W = 12;
  localparam int GROUP_LSB = 12;
  localparam int GROUP_W = 4;
  localparam logic [15:0] CLR_ALL = 16'hFFFF;
  localparam logic [15:0] FLAGS_RST = 16'hFFFF;
  typedef enum logic [1:0] {
    Q_OFF = 2'b00,
    Q_AUTO = 2'b01,
    Q_MANUAL = 2'b10
  } qmode_t;
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_EVAL = 1'b1
  } fsm_t;
endpackage

// ===== logic/key_sync.sv
// Three-stage synchroniser and debounced edge finder for keypad pins
`timescale 1ns/100ps
module key_sync #(
  parameter int WIDTH = 21
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
    logic [WIDTH-1:0] rise;
  } sync_t;
  sync_t s;
  sync_t n;

  always_comb begin
    n = s;
    n.s1 = pin;
    n.s2 = s.s1;
    n.s3 = s.s2;
    // A level counts only once the second and third stages agree
    for (int i = 0; i < WIDTH; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        n.lvl[i] = s.s3[i];
      end
    end
    n.rise = n.lvl & ~s.lvl;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign level = s.lvl;
  assign rise = s.rise;
endmodule // key_sync

// ===== logic/msg_regs.sv
// Register exchange between a controller and the message display core
//
// Summary of operation
// - Flag bit 0 low: trigger message in word two, load data sets once.
// - Flag bit 1 high ignores data words; a trigger still loads them.
// - Word eight clears a queued message only while flag bit 2 is low.
// - Clear value 65535 empties the whole queue.
// - Lamps follow word nine only while flag bit 3 is low.
// - Word nine bit n drives lamp n+1, one means lit.
// - Flag bits 4 to 7 lock keypad editing of data sets 1 to 4.
// - Flag bit 8 enables the queue when queue mode is auto or manual.
// - Flag bit 13 low sends data sets only to the selected slave.
// - Word fifteen: unit number bits 0-11, group number bits 12-15.
// - Word three is priority; larger value wins over current message.
// - Input block is republished, with a pulse, whenever a value changes.
// - Input word one bits 0-3 echo the four validity flags.
// - Input word one bits 4-7 show which data set is being entered.
// - Entering bit sets on data set key, clears on enter key.
// - Input word one bits 8-11 flag data sets changed from the keypad.
// - Bit 12 shows a full queue, bit 13 slave validity, 14-15 zero.
// - Input word six reports function keys 1-16, one means pressed.
// - Words nine to fourteen carry clock fields when reporting selected.
`timescale 1ns/100ps
module msg_regs
  import msg_regs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ctl_we,
  input wire logic [3:0] ctl_waddr,
  input wire logic [15:0] ctl_wdata,
  input wire logic ctl_done,
  output logic ctl_busy,
  input wire logic [3:0] ctl_raddr,
  output logic [15:0] ctl_rdata,
  output logic in_update,
  input wire logic [3:0] dset_key_pin,
  input wire logic enter_key_pin,
  input wire logic [15:0] fkey_pin,
  input wire logic [15:0] entry_value,
  input wire logic queue_full,
  input wire logic [1:0] queue_mode,
  input wire logic clock_report_en,
  input wire logic [5:0][7:0] rtc_fields,
  input wire logic [15:0] cur_prio,
  output logic msg_trigger,
  output logic [15:0] msg_number,
  output logic [15:0] msg_priority,
  output logic msg_preempt,
  output logic queue_clear,
  output logic queue_clear_all,
  output logic [15:0] queue_clear_number,
  output logic queue_enable,
  output logic [15:0] lamps,
  output logic ds_forward,
  output logic ds_broadcast,
  output logic [UNIT_W-1:0] ds_unit,
  output logic [GROUP_W-1:0] ds_group,
  output logic [3:0][15:0] data_sets
);
  typedef struct packed {
    fsm_t st;
    logic [15:0][15:0] ow;
    logic [15:0][15:0] iw;
    logic [3:0][15:0] ds;
    logic [3:0] entering;
    logic [3:0] changed;
    logic [15:0] lamps;
    logic trig;
    logic [15:0] msg;
    logic [15:0] prio;
    logic preempt;
    logic clr;
    logic clr_all;
    logic [15:0] clr_msg;
    logic qen;
    logic fwd;
    logic bcast;
    logic [UNIT_W-1:0] unit;
    logic [GROUP_W-1:0] group;
    logic update;
    logic [15:0] rdata;
  } state_t;

  state_t s;
  state_t n;
  logic [20:0] key_lvl;
  logic [20:0] key_rise;
  logic [3:0] dset_rise;
  logic enter_rise;
  logic [15:0] fkey_lvl;
  logic [15:0] flags;
  logic [3:0] lock;
  logic eval_now;
  logic [15:0][15:0] blk;

  key_sync #(.WIDTH(21)) keys (
    .mclk(mclk),
    .rst(rst),
    .pin({enter_key_pin, dset_key_pin, fkey_pin}),
    .level(key_lvl),
    .rise(key_rise)
  );

  assign fkey_lvl = key_lvl[15:0];
  assign dset_rise = key_rise[19:16];
  assign enter_rise = key_rise[20];
  assign flags = s.ow[OW_FLAGS];
  assign lock = flags[FB_LOCK0+3:FB_LOCK0];
  assign eval_now = (s.st == ST_EVAL);

  always_comb begin
    n = s;
    n.trig = 1'b0;
    n.clr = 1'b0;
    n.fwd = 1'b0;
    if (ctl_we) begin
      n.ow[ctl_waddr] = ctl_wdata;
    end
    case (s.st)
      ST_IDLE: begin
        if (ctl_done) begin
          n.st = ST_EVAL;
        end
      end
      ST_EVAL: begin
        n.st = ST_IDLE;
        if (!flags[FB_MSG]) begin
          n.trig = 1'b1;
          n.msg = s.ow[OW_MSG];
          n.prio = s.ow[OW_PRIO];
          n.preempt = s.ow[OW_PRIO] > cur_prio;
          n.changed = 4'h0;
        end
        // A trigger reloads the data sets whatever flag bit 1 says
        if (!flags[FB_MSG] || !flags[FB_DS]) begin
          for (int i = 0; i < 4; i++) begin
            n.ds[i] = s.ow[OW_DS0+4'(i)];
          end
          n.fwd = 1'b1;
          n.bcast = flags[FB_SLAVE];
          n.unit = s.ow[OW_SLAVE][UNIT_LSB +: UNIT_W];
          n.group = s.ow[OW_SLAVE][GROUP_LSB +: GROUP_W];
        end
        if (!flags[FB_CLR]) begin
          n.clr = 1'b1;
          n.clr_msg = s.ow[OW_CLR];
          n.clr_all = (s.ow[OW_CLR] == CLR_ALL);
        end
        if (!flags[FB_LAMP]) begin
          n.lamps = s.ow[OW_LAMP];
        end
      end
      default: n.st = ST_IDLE;
    endcase
    n.qen = ((queue_mode == Q_AUTO) || (queue_mode == Q_MANUAL))
      && !flags[FB_QUEUE];
    // Keypad handled after the controller so an operator edit wins
    for (int i = 0; i < 4; i++) begin
      if (dset_rise[i] && !lock[i]) begin
        n.entering = 4'h0;
        n.entering[i] = 1'b1;
        n.changed = 4'h0;
      end
    end
    if (enter_rise && (s.entering != 4'h0)) begin
      for (int i = 0; i < 4; i++) begin
        if (s.entering[i]) begin
          n.ds[i] = entry_value;
          n.changed[i] = 1'b1;
        end
      end
      n.entering = 4'h0;
    end
    // Locking a set mid-edit abandons that edit
    n.entering = n.entering & ~lock;
    blk = '0;
    blk[IW_FLAGS][3:0] = flags[3:0];
    blk[IW_FLAGS][SB_ENTER0 +: 4] = s.entering;
    blk[IW_FLAGS][SB_CHG0 +: 4] = s.changed;
    blk[IW_FLAGS][SB_FULL] = queue_full;
    blk[IW_FLAGS][SB_SLAVE] = flags[FB_SLAVE];
    for (int i = 0; i < 4; i++) begin
      blk[IW_DS0+4'(i)] = s.ds[i];
    end
    // Disabled function keys read as not pressed
    blk[IW_FKEY] = fkey_lvl & ~s.ow[OW_FKEN];
    if (clock_report_en) begin
      for (int i = 0; i < 6; i++) begin
        blk[IW_CLK0+4'(i)] = {8'h00, rtc_fields[i]};
      end
    end
    n.iw = blk;
    n.update = (blk != s.iw);
    n.rdata = s.iw[ctl_raddr];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.ow[OW_FLAGS] <= FLAGS_RST;
    end else begin
      s <= n;
    end
  end

  assign ctl_busy = eval_now;
  assign ctl_rdata = s.rdata;
  assign in_update = s.update;
  assign msg_trigger = s.trig;
  assign msg_number = s.msg;
  assign msg_priority = s.prio;
  assign msg_preempt = s.preempt;
  assign queue_clear = s.clr;
  assign queue_clear_all = s.clr_all;
  assign queue_clear_number = s.clr_msg;
  assign queue_enable = s.qen;
  assign lamps = s.lamps;
  assign ds_forward = s.fwd;
  assign ds_broadcast = s.bcast;
  assign ds_unit = s.unit;
  assign ds_group = s.group;
  assign data_sets = s.ds;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  trig_fires_a: assert property (
    eval_now && !flags[FB_MSG] |=> msg_trigger
      && msg_number == $past(s.ow[OW_MSG]))
    else $error("valid message number did not trigger");
  trig_quiet_a: assert property (
    msg_trigger |-> $past(eval_now) && !$past(flags[FB_MSG]))
    else $error("trigger without valid message flag");
  ds_ignore_a: assert property (
    eval_now && flags[FB_MSG] && flags[FB_DS] && !enter_rise
      |=> !ds_forward && $stable(data_sets))
    else $error("data sets loaded while invalid");
  clear_gate_a: assert property (
    queue_clear |-> $past(eval_now) && !$past(flags[FB_CLR]))
    else $error("queue clear without valid flag");
  clear_all_a: assert property (
    eval_now && !flags[FB_CLR] && s.ow[OW_CLR] == CLR_ALL
      |=> queue_clear && queue_clear_all)
    else $error("clear all not flagged");
  lamp_hold_a: assert property (
    !(eval_now && !flags[FB_LAMP]) |=> $stable(lamps))
    else $error("lamps changed while word ignored");
  lamp_load_a: assert property (
    eval_now && !flags[FB_LAMP] |=> lamps == $past(s.ow[OW_LAMP]))
    else $error("lamp word not applied");
  key_lock_a: assert property (
    s.entering[0] == 1'b0 && flags[FB_LOCK0] |=> !s.entering[0])
    else $error("locked data set entered");
  enter_done_a: assert property (
    enter_rise && s.entering != 4'h0 && dset_rise == 4'h0
      |=> s.entering == 4'h0 && s.changed == $past(s.entering))
    else $error("enter key did not close edit");
  update_pulse_a: assert property (
    s.iw != $past(s.iw) |-> in_update)
    else $error("changed block not announced");
  flag_echo_a: assert property (
    !$past(rst) |-> s.iw[IW_FLAGS][3:0] == $past(flags[3:0])
      && s.iw[IW_FLAGS][15:14] == 2'b00)
    else $error("validity echo wrong");
  full_echo_a: assert property (
    !$past(rst) |-> s.iw[IW_FLAGS][SB_FULL] == $past(queue_full))
    else $error("queue full not reported");
  queue_en_a: assert property (
    queue_mode == Q_OFF |=> !queue_enable)
    else $error("queue enabled with mode off");
endmodule // msg_regs

// ===== test/plc_model.sv
// Controller-side model that writes the output word block and commits it
`timescale 1ns/100ps
module plc_model (
  input wire logic mclk,
  input wire logic ctl_busy,
  output logic ctl_we,
  output logic [3:0] ctl_waddr,
  output logic [15:0] ctl_wdata,
  output logic ctl_done
);
  // Busy level seen in the cycle after the commit was taken
  logic busy_seen = 1'b0;
  initial begin
    ctl_we = 1'b0;
    ctl_waddr = 4'h0;
    ctl_wdata = 16'h0000;
    ctl_done = 1'b0;
  end

  // Writes all sixteen words, commits them, returns once results are out
  task automatic send_block(input logic [15:0] w [16]);
    int i;
    for (i = 0; i < 16; i++) begin
      @(posedge mclk);
      ctl_we <= 1'b1;
      ctl_waddr <= i[3:0];
      ctl_wdata <= w[i];
    end
    @(posedge mclk);
    ctl_we <= 1'b0;
    // Released data bus toggles so a stale word is never mistaken for valid
    ctl_wdata <= ~ctl_wdata;
    ctl_done <= 1'b1;
    @(posedge mclk);
    ctl_done <= 1'b0;
    #1;
    busy_seen = ctl_busy;
    @(posedge mclk);
    #1;
  endtask
endmodule // plc_model

// ===== test/msg_regs_test.sv
// Self-checking bench for the controller register exchange block
`timescale 1ns/100ps
module msg_regs_test;
  import msg_regs_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ctl_we, ctl_done, ctl_busy, in_update;
  logic [3:0] ctl_waddr;
  logic [3:0] ctl_raddr = 4'h0;
  logic [15:0] ctl_wdata, ctl_rdata;
  logic [3:0] dset_key_pin = 4'h0;
  logic enter_key_pin = 1'b0;
  logic [15:0] fkey_pin = 16'h0000;
  logic [15:0] entry_value = 16'h0000;
  logic queue_full = 1'b0;
  logic [1:0] queue_mode = Q_AUTO;
  logic clock_report_en = 1'b0;
  logic [5:0][7:0] rtc_fields = '0;
  logic [15:0] cur_prio = 16'h0000;
  logic msg_trigger, msg_preempt, queue_clear, queue_clear_all;
  logic queue_enable, ds_forward, ds_broadcast;
  logic [15:0] msg_number, msg_priority, queue_clear_number, lamps;
  logic [UNIT_W-1:0] ds_unit;
  logic [GROUP_W-1:0] ds_group;
  logic [3:0][15:0] data_sets;
  logic [15:0] blk [16];
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;

  always #50 mclk = ~mclk;

  plc_model i_plc_model (.mclk, .ctl_busy, .ctl_we, .ctl_waddr, .ctl_wdata,
    .ctl_done);

  msg_regs i_msg_regs (.mclk, .rst, .ctl_we, .ctl_waddr, .ctl_wdata,
    .ctl_done, .ctl_busy, .ctl_raddr, .ctl_rdata, .in_update, .dset_key_pin,
    .enter_key_pin, .fkey_pin, .entry_value, .queue_full, .queue_mode,
    .clock_report_en, .rtc_fields, .cur_prio, .msg_trigger, .msg_number,
    .msg_priority, .msg_preempt, .queue_clear, .queue_clear_all,
    .queue_clear_number, .queue_enable, .lamps, .ds_forward, .ds_broadcast,
    .ds_unit, .ds_group, .data_sets);

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge mclk);
    ctl_raddr <= a;
    @(posedge mclk);
    #1;
    chk(ctl_rdata, exp);
  endtask

  // Key pins pass a three-flop synchroniser, so hold each level long enough
  task automatic key(input logic [3:0] d, input logic e);
    @(posedge mclk);
    dset_key_pin <= d;
    enter_key_pin <= e;
    repeat (8) @(posedge mclk);
    dset_key_pin <= 4'h0;
    enter_key_pin <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask

  task automatic t_trigger;
    int k;
    blk = '{16'h0000, 16'h0100, 16'h0010, 16'h0123, 16'h4567, 16'h89AB,
      16'hCDEF, 16'h004F, 16'h8821, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, {4'h1, 12'h001}, 16'h0000};
    i_plc_model.send_block(blk);
    chk(msg_trigger, 16'h0001);
    chk(msg_number, 16'h0100);
    chk(msg_priority, 16'h0010);
    chk(msg_preempt, 16'h0001);
    chk(ds_forward, 16'h0001);
    chk(data_sets[3], 16'hCDEF);
    chk(queue_clear, 16'h0001);
    chk(queue_clear_number, 16'h004F);
    chk(queue_clear_all, 16'h0000);
    chk(lamps, 16'h8821);
    chk(queue_enable, 16'h0001);
    chk({ds_group, ds_unit}, 16'h1001);
    chk(ds_broadcast, 16'h0000);
    chk(i_plc_model.busy_seen, 16'h0001);
    chk(ctl_busy, 16'h0000);
    k = 0;
    while (in_update !== 1'b1 && k < 4) begin
      @(posedge mclk);
      #1;
      k++;
    end
    chk(in_update, 16'h0001);
    rd(IW_FLAGS, 16'h0000);
    rd(IW_DS0, 16'h0123);
    rd(4'h6, 16'h0000);
    @(posedge mclk);
    queue_mode <= Q_OFF;
    repeat (2) @(posedge mclk);
    #1;
    chk(queue_enable, 16'h0000);
    @(posedge mclk);
    queue_mode <= Q_MANUAL;
    repeat (2) @(posedge mclk);
    #1;
    chk(queue_enable, 16'h0001);
    @(posedge mclk);
    queue_mode <= Q_AUTO;
    $display("test trigger done");
  endtask

  task automatic t_invalid;
    @(posedge mclk);
    queue_full <= 1'b1;
    blk = '{16'hFFFF, 16'h0200, 16'h0001, 16'h1111, 16'h1111, 16'h1111,
      16'h1111, 16'h0001, 16'h1234, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000};
    i_plc_model.send_block(blk);
    chk(msg_trigger, 16'h0000);
    chk(data_sets[0], 16'h0123);
    chk(queue_clear, 16'h0000);
    chk(lamps, 16'h8821);
    chk(queue_enable, 16'h0000);
    // Slave routing is latched only with a data set load, so it holds here
    chk(ds_broadcast, 16'h0000);
    rd(IW_FLAGS, 16'h300F);
    $display("test invalid done");
  endtask

  task automatic t_clear_all;
    @(posedge mclk);
    queue_full <= 1'b0;
    blk[0] = 16'hFFF9;
    blk[7] = CLR_ALL;
    i_plc_model.send_block(blk);
    chk(ds_forward, 16'h0001);
    chk(data_sets[0], 16'h1111);
    chk(ds_broadcast, 16'h0001);
    chk(queue_clear, 16'h0001);
    chk(queue_clear_all, 16'h0001);
    chk(msg_trigger, 16'h0000);
    $display("test clear all done");
  endtask

  task automatic t_keypad;
    @(posedge mclk);
    fkey_pin <= 16'h1032;
    clock_report_en <= 1'b1;
    rtc_fields[0] <= 8'h5D;
    blk[0] = 16'hFF0F;
    i_plc_model.send_block(blk);
    key(4'h1, 1'b0);
    rd(IW_FLAGS, 16'h201F);
    @(posedge mclk);
    entry_value <= 16'h0042;
    key(4'h0, 1'b1);
    rd(IW_FLAGS, 16'h210F);
    rd(IW_DS0, 16'h0042);
    rd(IW_FKEY, 16'h1032);
    rd(IW_CLK0, 16'h005D);
    blk[0] = 16'hFF1F;
    i_plc_model.send_block(blk);
    key(4'h1, 1'b0);
    rd(IW_FLAGS, 16'h210F);
    @(posedge mclk);
    clock_report_en <= 1'b0;
    rd(IW_CLK0, 16'h0000);
    $display("test keypad done");
  endtask

  task report_and_stop;
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // The whole run needs under two hundred cycles; this bound catches a hang
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      report_and_stop;
    end
  end

  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_trigger;
    t_invalid;
    t_clear_all;
    t_keypad;
    report_and_stop;
  end
endmodule // msg_regs_test
